/* File: hw/emi_write_params.svh */
// Register offsets, field positions, reset values and timing counts for the table-write path
`ifndef EMI_WRITE_PARAMS_SVH
`define EMI_WRITE_PARAMS_SVH

`define OFF_MEM_CONTROL 8'h00
`define OFF_TABLE_LATCH 8'h04
`define OFF_TABLE_POINTER 8'h08
`define OFF_COMMAND 8'h0C
`define OFF_STATUS 8'h10
`define OFF_CONFIG_BYTE_THREE_LOW 8'h14

`define MODE_LSB 0
`define MODE_MSB 1
`define WAIT_LSB 4
`define WAIT_MSB 5
`define CMD_WRITE_BIT 2
`define CMD_READ_BIT 1
`define CMD_POSTINC_BIT 0
`define CFG_WAIT_DIS_BIT 7
`define STATUS_BUSY_BIT 0
`define STATUS_HOLD_LSB 8
`define STATUS_HOLD_MSB 15

`define MEM_CONTROL_RESET 8'h00
`define CONFIG_BYTE_THREE_LOW_RESET 8'h80
`define QUARTERS_PER_INSTR 4'h4

`endif

/* File: hw/emi_write_pkg.sv */
// Types shared by the table-write path modules
package emi_write_pkg;

  // Bus cycle phases; sync phases only follow reads
  typedef enum logic [2:0] {
    PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_WAIT, PH_Q4, PH_SYNC_A, PH_SYNC_B
  } bus_phase_t;

  // Decoded write modes
  typedef enum logic [1:0] {
    WM_BYTE_WRITE, WM_BYTE_SELECT, WM_WORD
  } write_mode_t;

endpackage : emi_write_pkg

/* File: hw/pin_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
  output logic [WIDTH-1:0] pin_sync_out // Synchronised levels
);

  logic [WIDTH-1:0] stage_one;

  ////////////////////////////////////////////////////////////////
  // First stage feeds only the second, to contain metastability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= '0;
      pin_sync_out <= '0;
    end else begin
      stage_one <= pin_in;
      pin_sync_out <= stage_one;
    end
  end

endmodule : pin_sync
`default_nettype wire

/* File: hw/byte_lane_mux.sv */
// Data lane and strobe selection for the data part of a bus cycle
`timescale 1ns/1ps
`default_nettype none
module byte_lane_mux (
  input wire emi_write_pkg::write_mode_t mode, // Decoded write mode
  input wire logic data_phase, // Data part of the cycle
  input wire logic is_read, // Read cycle, not write
  input wire logic lsb, // Pointer byte bit
  input wire logic [7:0] latch_byte, // Table latch byte
  input wire logic [7:0] hold_byte, // Holding latch byte
  output logic [15:0] lane_data, // Bus data
  output logic drive_data, // Bus driven in data part
  output logic strobe_high_n, // High write strobe
  output logic strobe_low_n, // Low write strobe
  output logic upper_sel_n, // Upper byte select
  output logic lower_sel_n // Lower byte select
);

  ////////////////////////////////////////////////////////////////
  // Idle levels first, then per-mode overrides
  always_comb begin
    lane_data = {latch_byte, latch_byte};
    drive_data = 1'b0;
    strobe_high_n = 1'b1;
    strobe_low_n = 1'b1;
    upper_sel_n = 1'b1;
    lower_sel_n = 1'b1;
    if (data_phase && is_read) begin
      upper_sel_n = 1'b0; // Whole word is read
      lower_sel_n = 1'b0;
    end else if (data_phase) begin
      unique case (mode)
        emi_write_pkg::WM_WORD: begin
          lane_data = {latch_byte, hold_byte};
          if (lsb) begin
            drive_data = 1'b1;
            strobe_high_n = 1'b0;
            upper_sel_n = 1'b0;
            lower_sel_n = 1'b0;
          end
        end
        emi_write_pkg::WM_BYTE_SELECT: begin
          drive_data = 1'b1;
          strobe_high_n = 1'b0;
          upper_sel_n = ~lsb;
          lower_sel_n = lsb;
        end
        emi_write_pkg::WM_BYTE_WRITE: begin
          drive_data = 1'b1;
          strobe_high_n = ~lsb;
          strobe_low_n = lsb;
          upper_sel_n = 1'b0;
          lower_sel_n = 1'b0;
        end
      endcase
    end
  end

endmodule : byte_lane_mux
`default_nettype wire

/* File: hw/emi_write_path.sv */
// Table-write path of a 16-bit multiplexed external memory bus with APB registers
// What this block does
// - Control bits 1:0 pick mode: 1x word, 01 byte select, 00 byte write.
// - Word mode even write: latch byte to holding latch, bus floats, no strobe.
// - Word mode odd write: latch byte high, holding byte low, same cycle.
// - Word mode odd write: high strobe pulses, low strobe idle, both selects low.
// - Word mode still shows pointer byte bit on byte address output.
// - Byte select mode: latch byte copied onto both bus halves.
// - Byte select mode: high strobe pulses every write, low strobe idle.
// - Byte select mode: byte address and selects follow pointer byte bit.
// - Byte write mode: latch byte on both bus halves.
// - Byte write mode: even pulses low strobe only, odd high strobe only.
// - Wait states only possible while config wait-disable bit is clear.
// - Wait count from control bits 5:4, each one instruction cycle long.
// - Wait states stretch the active-low output enable.
// - Each access copies pointer bit 0 out and pointer bits 20:1 to address.
// - Idle: address and data float, active-low lines high, latch strobe low.
// - First quarter raises latch strobe with low address bits on the bus.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "emi_write_params.svh"
module emi_write_path #(
  parameter int PTR_W = 21,
  parameter int WAIT_CNT_W = 4
) (
  input wire logic pclk, // Core clock, one quarter cycle
  input wire logic presetn, // Async reset, active low
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic [19:0] addr_out, // Upper address pins
  output logic addr_oe, // Address pins driven
  input wire logic [15:0] ad_in, // Multiplexed bus in
  output logic [15:0] ad_out, // Multiplexed bus out
  output logic ad_oe, // Multiplexed bus driven
  output logic addr_latch_enable, // Address latch strobe
  output logic output_enable_n, // Memory output enable
  output logic write_strobe_high_n, // High write strobe
  output logic write_strobe_low_n, // Low write strobe
  output logic upper_byte_select_n, // Upper byte select
  output logic lower_byte_select_n, // Lower byte select
  output logic byte_address_bit // Byte address
);

  emi_write_pkg::bus_phase_t phase;
  emi_write_pkg::bus_phase_t next_phase;
  emi_write_pkg::write_mode_t mode;
  logic [7:0] memory_interface_control;
  logic [7:0] config_byte_three_low;
  logic [7:0] table_data_latch;
  logic [PTR_W-1:0] table_pointer;
  logic [7:0] holding_latch;
  logic is_read;
  logic post_inc;
  logic next_is_read;
  logic [WAIT_CNT_W-1:0] wait_left;
  logic [WAIT_CNT_W-1:0] wait_total;
  logic [1:0] wait_eff;
  logic [15:0] ad_sync;
  logic busy;
  logic wr_acc;
  logic start;
  logic op_done;
  logic mapped;
  logic [31:0] next_prdata;
  logic next_data_phase;
  logic [15:0] lane_data;
  logic drive_data;
  logic strobe_high_n;
  logic strobe_low_n;
  logic upper_sel_n;
  logic lower_sel_n;

  ////////////////////////////////////////////////////////////////
  // Mode decode and effective wait count
  always_comb begin
    if (memory_interface_control[`MODE_MSB]) begin
      mode = emi_write_pkg::WM_WORD;
    end else if (memory_interface_control[`MODE_LSB]) begin
      mode = emi_write_pkg::WM_BYTE_SELECT;
    end else begin
      mode = emi_write_pkg::WM_BYTE_WRITE;
    end
  end

  // Wait-disable bit set forces zero wait states
  assign wait_eff = config_byte_three_low[`CFG_WAIT_DIS_BIT] ? 2'h0
                    : memory_interface_control[`WAIT_MSB:`WAIT_LSB];
  assign wait_total = WAIT_CNT_W'(wait_eff) * WAIT_CNT_W'(`QUARTERS_PER_INSTR);

  ////////////////////////////////////////////////////////////////
  // APB slave: zero-wait, writes refused while a bus cycle runs
  assign busy = (phase != emi_write_pkg::PH_IDLE);
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite && !busy;
  assign mapped = (paddr == `OFF_MEM_CONTROL) || (paddr == `OFF_TABLE_LATCH)
                  || (paddr == `OFF_TABLE_POINTER) || (paddr == `OFF_COMMAND)
                  || (paddr == `OFF_STATUS) || (paddr == `OFF_CONFIG_BYTE_THREE_LOW);
  assign pslverr = psel && penable && !mapped;
  assign start = wr_acc && (paddr == `OFF_COMMAND)
                 && (pwdata[`CMD_WRITE_BIT] || pwdata[`CMD_READ_BIT]);
  // Write wins when both command bits are set
  assign next_is_read = start ? !pwdata[`CMD_WRITE_BIT] : is_read;

  // Read mux; the command register reads as zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `OFF_MEM_CONTROL: next_prdata[7:0] = memory_interface_control;
      `OFF_TABLE_LATCH: next_prdata[7:0] = table_data_latch;
      `OFF_TABLE_POINTER: next_prdata[PTR_W-1:0] = table_pointer;
      `OFF_STATUS: begin
        next_prdata[`STATUS_BUSY_BIT] = busy;
        next_prdata[`STATUS_HOLD_MSB:`STATUS_HOLD_LSB] = holding_latch;
      end
      `OFF_CONFIG_BYTE_THREE_LOW: next_prdata[7:0] = config_byte_three_low;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup so it comes from a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_interface_control <= `MEM_CONTROL_RESET;
      config_byte_three_low <= `CONFIG_BYTE_THREE_LOW_RESET;
    end else if (wr_acc && paddr == `OFF_MEM_CONTROL) begin
      memory_interface_control <= pwdata[7:0];
    end else if (wr_acc && paddr == `OFF_CONFIG_BYTE_THREE_LOW) begin
      config_byte_three_low <= pwdata[7:0];
    end
  end

  // Command options held for the cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_read <= 1'b0;
      post_inc <= 1'b0;
    end else if (start) begin
      is_read <= next_is_read;
      post_inc <= pwdata[`CMD_POSTINC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus cycle sequencer; reads add two phases for the pin synchroniser
  always_comb begin
    next_phase = phase;
    unique case (phase)
      emi_write_pkg::PH_IDLE: if (start) next_phase = emi_write_pkg::PH_Q1;
      emi_write_pkg::PH_Q1: next_phase = emi_write_pkg::PH_Q2;
      emi_write_pkg::PH_Q2: next_phase = emi_write_pkg::PH_Q3;
      emi_write_pkg::PH_Q3: begin
        // Writes have no output enable to stretch
        if (is_read && wait_total != '0) begin
          next_phase = emi_write_pkg::PH_WAIT;
        end else begin
          next_phase = emi_write_pkg::PH_Q4;
        end
      end
      emi_write_pkg::PH_WAIT: begin
        if (wait_left == WAIT_CNT_W'(1)) next_phase = emi_write_pkg::PH_Q4;
      end
      emi_write_pkg::PH_Q4: begin
        next_phase = is_read ? emi_write_pkg::PH_SYNC_A : emi_write_pkg::PH_IDLE;
      end
      emi_write_pkg::PH_SYNC_A: next_phase = emi_write_pkg::PH_SYNC_B;
      emi_write_pkg::PH_SYNC_B: next_phase = emi_write_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= emi_write_pkg::PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Wait countdown, one instruction cycle per wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_left <= '0;
    end else if (phase == emi_write_pkg::PH_Q3) begin
      wait_left <= wait_total;
    end else if (phase == emi_write_pkg::PH_WAIT) begin
      wait_left <= wait_left - WAIT_CNT_W'(1);
    end
  end

  assign op_done = (phase == emi_write_pkg::PH_SYNC_B)
                   || (phase == emi_write_pkg::PH_Q4 && !is_read);

  ////////////////////////////////////////////////////////////////
  // Table pointer; hardware update never meets a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_pointer <= '0;
    end else if (op_done && post_inc) begin
      table_pointer <= table_pointer + PTR_W'(1);
    end else if (wr_acc && paddr == `OFF_TABLE_POINTER) begin
      table_pointer <= pwdata[PTR_W-1:0];
    end
  end

  // Even word-mode write parks the latch byte for its odd partner
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      holding_latch <= 8'h00;
    end else if (phase == emi_write_pkg::PH_Q4 && !is_read
                 && mode == emi_write_pkg::WM_WORD && !table_pointer[0]) begin
      holding_latch <= table_data_latch;
    end
  end

  // Table latch: software load, or the selected byte of a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_data_latch <= 8'h00;
    end else if (phase == emi_write_pkg::PH_SYNC_B) begin
      table_data_latch <= table_pointer[0] ? ad_sync[15:8] : ad_sync[7:0];
    end else if (wr_acc && paddr == `OFF_TABLE_LATCH) begin
      table_data_latch <= pwdata[7:0];
    end
  end

  // Bus input crosses in through two flops
  pin_sync #(
    .WIDTH(16)
  ) u_ad_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(ad_in),
    .pin_sync_out(ad_sync)
  );

  ////////////////////////////////////////////////////////////////
  // Pin outputs registered from the next phase so they line up with it
  assign next_data_phase = (next_phase == emi_write_pkg::PH_Q3)
                           || (next_phase == emi_write_pkg::PH_WAIT)
                           || (next_phase == emi_write_pkg::PH_Q4);

  byte_lane_mux u_lane (
    .mode(mode),
    .data_phase(next_data_phase),
    .is_read(next_is_read),
    .lsb(table_pointer[0]),
    .latch_byte(table_data_latch),
    .hold_byte(holding_latch),
    .lane_data(lane_data),
    .drive_data(drive_data),
    .strobe_high_n(strobe_high_n),
    .strobe_low_n(strobe_low_n),
    .upper_sel_n(upper_sel_n),
    .lower_sel_n(lower_sel_n)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_out <= 20'h0_0000;
      addr_oe <= 1'b0;
      ad_out <= 16'h0000;
      ad_oe <= 1'b0;
      addr_latch_enable <= 1'b0;
      output_enable_n <= 1'b1;
      write_strobe_high_n <= 1'b1;
      write_strobe_low_n <= 1'b1;
      upper_byte_select_n <= 1'b1;
      lower_byte_select_n <= 1'b1;
      byte_address_bit <= 1'b0;
    end else if (next_phase == emi_write_pkg::PH_IDLE || next_phase == emi_write_pkg::PH_SYNC_A
                 || next_phase == emi_write_pkg::PH_SYNC_B) begin
      addr_out <= 20'h0_0000;
      addr_oe <= 1'b0;
      ad_out <= 16'h0000;
      ad_oe <= 1'b0;
      addr_latch_enable <= 1'b0;
      output_enable_n <= 1'b1;
      write_strobe_high_n <= 1'b1;
      write_strobe_low_n <= 1'b1;
      upper_byte_select_n <= 1'b1;
      lower_byte_select_n <= 1'b1;
      byte_address_bit <= 1'b0;
    end else begin
      addr_out <= table_pointer[PTR_W-1:1];
      addr_oe <= 1'b1;
      byte_address_bit <= table_pointer[0];
      addr_latch_enable <= (next_phase == emi_write_pkg::PH_Q1);
      if (next_data_phase) begin
        ad_out <= lane_data;
        ad_oe <= drive_data && !next_is_read;
      end else begin
        ad_out <= table_pointer[16:1];
        ad_oe <= 1'b1;
      end
      output_enable_n <= !(next_data_phase && next_is_read);
      write_strobe_high_n <= strobe_high_n;
      write_strobe_low_n <= strobe_low_n;
      upper_byte_select_n <= upper_sel_n;
      lower_byte_select_n <= lower_sel_n;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_data;
  logic [WAIT_CNT_W:0] oe_low_cnt;
  assign wr_data = (phase == emi_write_pkg::PH_Q3 || phase == emi_write_pkg::PH_Q4) && !is_read;

  // Length of each output-enable pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_low_cnt <= '0;
    end else if (!output_enable_n) begin
      oe_low_cnt <= oe_low_cnt + (WAIT_CNT_W+1)'(1);
    end else begin
      oe_low_cnt <= '0;
    end
  end

  sequence s_addr_phase;
    addr_latch_enable && ad_oe && (ad_out == table_pointer[16:1]) ##1 !addr_latch_enable && ad_oe;
  endsequence
  sequence s_data_phase;
    phase == emi_write_pkg::PH_Q3;
  endsequence

  property p_word_even;
    wr_data && mode == emi_write_pkg::WM_WORD && !table_pointer[0]
      |-> !ad_oe && write_strobe_high_n && write_strobe_low_n && upper_byte_select_n;
  endproperty
  a_word_even: assert property (p_word_even) else $error("word even write drove bus");

  property p_word_hold;
    phase == emi_write_pkg::PH_Q4 && !is_read && mode == emi_write_pkg::WM_WORD && !table_pointer[0]
      |=> holding_latch == $past(table_data_latch);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("holding latch not loaded");

  property p_word_odd;
    wr_data && mode == emi_write_pkg::WM_WORD && table_pointer[0]
      |-> ad_oe && ad_out == {table_data_latch, holding_latch} && !write_strobe_high_n
          && write_strobe_low_n && !upper_byte_select_n && !lower_byte_select_n;
  endproperty
  a_word_odd: assert property (p_word_odd) else $error("word odd write wrong");

  property p_dup_byte;
    wr_data && mode != emi_write_pkg::WM_WORD
      |-> ad_oe && ad_out == {table_data_latch, table_data_latch};
  endproperty
  a_dup_byte: assert property (p_dup_byte) else $error("latch byte not on both halves");

  property p_byte_select;
    wr_data && mode == emi_write_pkg::WM_BYTE_SELECT
      |-> !write_strobe_high_n && write_strobe_low_n
          && upper_byte_select_n == !table_pointer[0] && lower_byte_select_n == table_pointer[0];
  endproperty
  a_byte_select: assert property (p_byte_select) else $error("byte select strobes wrong");

  property p_byte_write;
    wr_data && mode == emi_write_pkg::WM_BYTE_WRITE
      |-> write_strobe_high_n == !table_pointer[0] && write_strobe_low_n == table_pointer[0];
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write strobe wrong");

  property p_address;
    phase inside {emi_write_pkg::PH_Q1, emi_write_pkg::PH_Q2, emi_write_pkg::PH_Q3}
      |-> addr_oe && addr_out == table_pointer[PTR_W-1:1] && byte_address_bit == table_pointer[0];
  endproperty
  a_address: assert property (p_address) else $error("address pins wrong");

  property p_idle;
    phase == emi_write_pkg::PH_IDLE |-> !ad_oe && !addr_oe && !addr_latch_enable && !byte_address_bit
      && output_enable_n && write_strobe_high_n && write_strobe_low_n
      && upper_byte_select_n && lower_byte_select_n;
  endproperty
  a_idle: assert property (p_idle) else $error("idle levels wrong");

  property p_ale;
    start |=> s_addr_phase ##1 s_data_phase;
  endproperty
  a_ale: assert property (p_ale) else $error("address phase wrong");

  property p_oe_len;
    $rose(output_enable_n) |-> oe_low_cnt == (WAIT_CNT_W+1)'(2) + (WAIT_CNT_W+1)'(wait_total);
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("output enable length wrong");

  property p_post_inc;
    op_done && post_inc |=> table_pointer == $past(table_pointer) + PTR_W'(1);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("pointer not advanced");

endmodule : emi_write_path
`default_nettype wire

/* File: tb/ext_mem_model.sv */
// Word-wide memory behind an address latch, logging what it sees
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic pclk, // Core clock
  input wire logic [19:0] addr_out, // Upper address pins
  input wire logic [15:0] ad_out, // Bus from device
  input wire logic ale, // Latch strobe
  input wire logic oe_n, // Output enable
  input wire logic wh_n, // High write strobe
  input wire logic wl_n, // Low write strobe
  input wire logic [2:0] sel, // Selects and byte bit
  output logic [15:0] ad_in, // Bus to device
  output logic [35:0] lat, // Latched address
  output logic [15:0] wd, // Data under a strobe
  output logic [2:0] wsel, // Selects under a strobe
  output logic [7:0] nh, // High strobe cycles
  output logic [7:0] nl, // Low strobe cycles
  output logic [7:0] n_oe // Enable cycles
);
  initial begin
    {ad_in, lat, wd, wsel, nh, nl, n_oe} = '0;
  end
  // Address is latched while the strobe is high
  always @(posedge pclk) begin
    if (ale) lat <= {addr_out, ad_out};
    if (!wh_n || !wl_n) wd <= ad_out;
    if (!wh_n || !wl_n) wsel <= sel;
    nh <= nh + 8'(!wh_n);
    nl <= nl + 8'(!wl_n);
    n_oe <= n_oe + 8'(!oe_n);
  end
  // Released bus flips every cycle so stale data is never mistaken
  always @(posedge pclk) ad_in <= !oe_n ? lat[15:0] ^ 16'h5A3C : ~ad_in;
endmodule : ext_mem_model
`default_nettype wire

/* File: tb/emi_write_path_test.sv */
// Self-checking bench for the table-write path
`timescale 1ns/1ps
`default_nettype none
`include "emi_write_params.svh"
module emi_write_path_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic addr_oe, ad_oe, ale, oe_n, wh_n, wl_n, ub_n, lb_n, ba;
  logic [7:0] paddr, nh, nl, n_oe, h0, l0, o0, lb, hold;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed = 32'hFB0C4410;
  logic [19:0] addr_out;
  logic [15:0] ad_in, ad_out, wd, w;
  logic [35:0] lat;
  logic [2:0] wsel;
  logic [20:0] ptr;
  int err_total = 0;
  int n_tests = 0;
  int m, k;
  emi_write_path uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .addr_out(addr_out), .addr_oe(addr_oe),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .addr_latch_enable(ale),
    .output_enable_n(oe_n), .write_strobe_high_n(wh_n), .write_strobe_low_n(wl_n),
    .upper_byte_select_n(ub_n), .lower_byte_select_n(lb_n), .byte_address_bit(ba));
  ext_mem_model mem (.pclk(pclk), .addr_out(addr_out), .ad_out(ad_out), .ale(ale),
    .oe_n(oe_n), .wh_n(wh_n), .wl_n(wl_n), .sel({ub_n, lb_n, ba}), .ad_in(ad_in),
    .lat(lat), .wd(wd), .wsel(wsel), .nh(nh), .nl(nl), .n_oe(n_oe));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // One APB transfer; held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      test_done();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll busy with a bound; a hang ends the run
  task automatic idle();
    int i;
    for (i = 0; i < 40; i++) begin
      apb(`OFF_STATUS, 1'b0, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 40) begin
      err_total++;
      test_done();
    end
  endtask : idle
  // Strobe cycle counts {high, low}, two quarters per pulse
  function automatic logic [15:0] exp_cnt(input int md, input int odd);
    if (md > 1) return odd ? 16'h0200 : 16'h0000;
    if (md == 1 || odd) return 16'h0200;
    return 16'h0002;
  endfunction : exp_cnt
  // Bus data, upper/lower select and byte bit under the strobe
  function automatic logic [18:0] exp_bus(input int md, input int odd, input logic [7:0] b,
      input logic [7:0] h);
    logic s;
    s = odd[0];
    if (md > 1) return {b, h, 3'b001};
    if (md == 1) return {b, b, ~s, s, s};
    return {b, b, 2'b00, s};
  endfunction : exp_bus
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, an unmapped place, idle pins
    apb(`OFF_MEM_CONTROL, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(`OFF_CONFIG_BYTE_THREE_LOW, 1'b0, 32'h0);
    chk(rd, 32'h80);
    apb(8'h20, 1'b0, 32'h0);
    chk({slv, rd}, {1'b1, 32'h0});
    chk({addr_oe, ad_oe, ale, ba, oe_n, wh_n, wl_n, ub_n, lb_n}, 9'h01F);
    $display("Reset test done");
    // Every mode code, even then odd pairs, carry across pointer bytes
    for (m = 0; m < 4; m++) begin
      apb(`OFF_MEM_CONTROL, 1'b1, m);
      ptr = (m == 0) ? 21'h0FFFFE : rnd();
      ptr[0] = 1'b0;
      apb(`OFF_TABLE_POINTER, 1'b1, 32'(ptr));
      for (k = 0; k < 2; k++) begin
        lb = rnd();
        apb(`OFF_TABLE_LATCH, 1'b1, 32'(lb));
        h0 = nh;
        l0 = nl;
        apb(`OFF_COMMAND, 1'b1, 32'h5);
        idle();
        chk(lat, {ptr[20:1], ptr[16:1]});
        chk({nh - h0, nl - l0}, exp_cnt(m, k));
        if (m > 1 && k == 0) begin
          hold = lb;
          apb(`OFF_STATUS, 1'b0, 32'h0);
          chk(rd[15:8], lb);
        end else begin
          chk({wd, wsel}, exp_bus(m, k, lb, hold));
        end
        chk({addr_oe, ad_oe, ale, ba, wh_n, wl_n}, 6'h03);
        ptr = ptr + 21'h1;
        apb(`OFF_TABLE_POINTER, 1'b0, 32'h0);
        chk(rd, 32'(ptr));
      end
    end
    $display("Write mode test done");
    // Wait states: disabled by config, then counts 1 and 2
    for (m = 0; m < 3; m++) begin
      apb(`OFF_CONFIG_BYTE_THREE_LOW, 1'b1, m ? 32'h0 : 32'h80);
      apb(`OFF_MEM_CONTROL, 1'b1, 32'((m ? m : 3) << 4));
      ptr = rnd();
      ptr[0] = m[0];
      apb(`OFF_TABLE_POINTER, 1'b1, 32'(ptr));
      o0 = n_oe;
      apb(`OFF_COMMAND, 1'b1, 32'h2);
      idle();
      chk(8'(n_oe - o0), 8'(2 + 4 * m));
      w = ptr[16:1] ^ 16'h5A3C;
      apb(`OFF_TABLE_LATCH, 1'b0, 32'h0);
      chk(rd, ptr[0] ? w[15:8] : w[7:0]);
    end
    $display("Wait state test done");
    test_done();
  end
endmodule : emi_write_path_test
`default_nettype wire
